// File: cdg_cfg.svh
// Purpose: constants for the complementary dead-band generator
// Assumes: 100 MHz ref_clk, Avalon-MM word addressing by byte offset
// Notes: offsets are byte addresses, one 32-bit word per register
`ifndef CDG_CFG_SVH
`define CDG_CFG_SVH
`define CDG_OFS_CTRL0 4'h0
`define CDG_OFS_CTRL1 4'h4
`define CDG_OFS_CTRL2 4'h8
`define CDG_OFS_DBR 4'hC
`define CDG_ADDR_W 4
`define CDG_CTRL0_RST 8'h00
`define CDG_CTRL1_RST 8'h00
`define CDG_CTRL2_RST 8'h00
`define CDG_DB_RST 6'h00
`define CDG_OFS_DBF_IDX 4'h0
`endif

// File: cdg_complementary_generator.sv
// Purpose: complementary_generator with dead band and auto-shutdown
// Assumes: Avalon-MM slave, 32-bit data, byte offsets; ref_clk is system clock
// Notes: fast oscillator select modelled as a divided tick enable of ref_clk
//
// The register offsets and the Avalon-MM register port were decided locally.
`include "cdg_cfg.svh"
// Functional notes
// - outputs A and B from one input
// - clock select: system clock or fast oscillator
// - three-bit input source select field
// - source encoding cell1, osc, pwm_unit4..1, cmp1, cmp2
// - enable starts with both drives cleared
// - output enables gate pins; module enable dominates
// - per-output polarity, not applied to high/low overrides; inactive override follows it
// - independent six-bit rising and falling counts, one shared counter
// - count clock periods up to programmed value
// - rising edge: B off, count, then A
// - falling edge: A off, count, then B
// - zero count bypasses dead band
// - short pulse never turns output on
// - software shutdown holds while bit set
// - auto-restart clears software shutdown bit
// - enabled external source forces overrides immediately
// - four individually enabled shutdown sources
// - sources level sensitive, hold shutdown while active
// - two-bit override level per output
// - override encoding high, low, tristate, inactive
// - software clear only when sources low
// - overrides persist until next rising edge
// - auto-restart clears bit when sources low
module cdg_complementary_generator
	import cdg_pkg::*;
#(
	parameter int OSC_DIV = 6
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic comparator1_async_out,
	input wire logic comparator2_async_out,
	input wire logic pwm_unit1,
	input wire logic pwm_unit2,
	input wire logic pwm_unit3,
	input wire logic pwm_unit4,
	input wire logic oscillator_out,
	input wire logic logic_cell1_out,
	input wire logic logic_cell2_out,
	input wire logic fault_pin_n,
	output logic drive_out_a,
	output logic drive_out_a_oe,
	output logic drive_out_b,
	output logic drive_out_b_oe
);
	cdg_cfg_s cfg_reg, cfg_next;
	cdg_state_s st_reg, st_next;
	cdg_pins_s pins_reg, pins_next;
	logic [2:0] div_reg, div_next;
	logic [7:0] src_vec;
	logic [3:0] sd_raw;
	logic src_now;
	logic sd_active;
	logic tick;
	logic rise_ev;
	logic fall_ev;
	logic [5:0] target;
	logic wr_hit;
	logic rd_hit;
	logic sw_clear_try;
	logic sw_set_try;

	// synchroniser inputs; index equals source select code
	assign src_vec = {logic_cell1_out, oscillator_out, pwm_unit4, pwm_unit3,
		pwm_unit2, pwm_unit1, comparator1_async_out, comparator2_async_out};
	assign sd_raw = {comparator2_async_out, comparator1_async_out,
		~fault_pin_n, logic_cell2_out};

	// slave answers in the cycle after the request is seen
	assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.rvalid;
	assign avs_readdata = st_reg.rdata;
	assign wr_hit = avs_write & st_reg.rvalid;
	assign rd_hit = avs_read & ~st_reg.rvalid;

	// tick: every ref_clk, or divided rate for the fast oscillator
	assign tick = cfg_reg.deadband_clock_select ? st_reg.div_tick : 1'b1;
	assign src_now = st_reg.in_sync[1];
	assign rise_ev = src_now & ~st_reg.in_prev;
	assign fall_ev = ~src_now & st_reg.in_prev;
	assign sd_active = |(st_reg.sd_sync1 & cfg_reg.shutdown_source_en);
	assign sw_set_try = wr_hit && avs_address == `CDG_OFS_CTRL2 && avs_byteenable[0]
		&& avs_writedata[7];
	assign sw_clear_try = wr_hit && avs_address == `CDG_OFS_CTRL2 && avs_byteenable[0]
		&& !avs_writedata[7];

	always_comb
	begin
		cfg_next = cfg_reg;
		st_next = st_reg;
		div_next = div_reg + 3'h1;
		st_next.div_tick = 1'b0;
		if (div_reg == 3'(OSC_DIV - 1))
		begin
			div_next = 3'h0;
			st_next.div_tick = 1'b1;
		end
		st_next.in_sync = {st_reg.in_sync[0], src_vec[cfg_reg.input_source_select]};
		st_next.sd_sync0 = sd_raw;
		st_next.sd_sync1 = st_reg.sd_sync0;
		st_next.rvalid = (avs_read | avs_write) & ~st_reg.rvalid;
		target = st_reg.rise_phase ? cfg_reg.rising_deadband_count
			: cfg_reg.falling_deadband_count;
		if (rd_hit)
		begin
			unique case (avs_address)
				`CDG_OFS_CTRL0: st_next.rdata = {24'h0, cfg_reg.module_enable,
					cfg_reg.out_b_enable, cfg_reg.out_a_enable, cfg_reg.out_b_polarity,
					cfg_reg.out_a_polarity, 2'h0, cfg_reg.deadband_clock_select};
				`CDG_OFS_CTRL1: st_next.rdata = {24'h0, cfg_reg.out_b_override_level,
					cfg_reg.out_a_override_level, 1'b0, cfg_reg.input_source_select};
				`CDG_OFS_CTRL2: st_next.rdata = {24'h0, cfg_reg.shutdown_status,
					cfg_reg.auto_restart_enable, 2'h0, cfg_reg.shutdown_source_en};
				`CDG_OFS_DBR: st_next.rdata = {18'h0, cfg_reg.falling_deadband_count,
					2'h0, cfg_reg.rising_deadband_count};
				default: st_next.rdata = 32'h0;
			endcase
		end
		if (wr_hit && avs_byteenable[0])
		begin
			unique case (avs_address)
				`CDG_OFS_CTRL0:
				begin
					cfg_next.module_enable = avs_writedata[7];
					cfg_next.out_b_enable = avs_writedata[6];
					cfg_next.out_a_enable = avs_writedata[5];
					cfg_next.out_b_polarity = avs_writedata[4];
					cfg_next.out_a_polarity = avs_writedata[3];
					cfg_next.deadband_clock_select = avs_writedata[0];
				end
				`CDG_OFS_CTRL1:
				begin
					cfg_next.out_b_override_level = avs_writedata[7:6];
					cfg_next.out_a_override_level = avs_writedata[5:4];
					cfg_next.input_source_select = avs_writedata[2:0];
				end
				`CDG_OFS_CTRL2:
				begin
					cfg_next.auto_restart_enable = avs_writedata[6];
					cfg_next.shutdown_source_en = avs_writedata[3:0];
				end
				`CDG_OFS_DBR: cfg_next.rising_deadband_count = avs_writedata[5:0];
				default: cfg_next.module_enable = cfg_reg.module_enable;
			endcase
		end
		if (wr_hit && avs_byteenable[1] && avs_address == `CDG_OFS_DBR)
			cfg_next.falling_deadband_count = avs_writedata[13:8];
		// shutdown status: hardware set beats any clear
		if (sw_set_try)
			cfg_next.shutdown_status = 1'b1;
		else if (sw_clear_try && !cfg_reg.auto_restart_enable && !sd_active)
			cfg_next.shutdown_status = 1'b0;
		if (cfg_reg.auto_restart_enable && !sd_active && !sw_set_try)
			cfg_next.shutdown_status = 1'b0;
		if (sd_active && cfg_reg.module_enable)
			cfg_next.shutdown_status = 1'b1;
		// dead-band engine
		if (tick)
			st_next.in_prev = src_now;
		if (!cfg_reg.module_enable)
		begin
			st_next.a_on = 1'b0;
			st_next.b_on = 1'b0;
			st_next.counting = 1'b0;
			st_next.held = 1'b1;
		end
		else if (!st_reg.was_en)
		begin
			st_next.a_on = 1'b0;
			st_next.b_on = 1'b0;
			st_next.counting = 1'b0;
			st_next.held = 1'b1;
		end
		else if (tick)
		begin
			if (rise_ev)
			begin
				st_next.b_on = 1'b0;
				st_next.rise_phase = 1'b1;
				st_next.cnt = 7'h0;
				st_next.counting = cfg_reg.rising_deadband_count != `CDG_DB_RST;
				st_next.a_on = cfg_reg.rising_deadband_count == `CDG_DB_RST;
				if (!cfg_reg.shutdown_status)
					st_next.held = 1'b0;
			end
			else if (fall_ev)
			begin
				st_next.a_on = 1'b0;
				st_next.rise_phase = 1'b0;
				st_next.cnt = 7'h0;
				st_next.counting = cfg_reg.falling_deadband_count != `CDG_DB_RST;
				st_next.b_on = cfg_reg.falling_deadband_count == `CDG_DB_RST;
			end
			else if (st_reg.counting)
			begin
				st_next.cnt = st_reg.cnt + 7'h1;
				if (st_reg.cnt + 7'h1 >= {1'b0, target})
				begin
					st_next.counting = 1'b0;
					st_next.a_on = st_reg.rise_phase;
					st_next.b_on = ~st_reg.rise_phase;
				end
			end
		end
		if (cfg_reg.shutdown_status || sd_active)
			st_next.held = 1'b1;
		st_next.was_en = cfg_reg.module_enable;
	end

	// pin resolve: normal waveform or override
	always_comb
	begin
		logic hold;
		hold = st_reg.held | cfg_reg.shutdown_status | sd_active;
		pins_next.a_out = st_reg.a_on ^ ~cfg_reg.out_a_polarity;
		pins_next.b_out = st_reg.b_on ^ ~cfg_reg.out_b_polarity;
		pins_next.a_oe = cfg_reg.out_a_enable;
		pins_next.b_oe = cfg_reg.out_b_enable;
		if (hold)
		begin
			unique case (cfg_reg.out_a_override_level)
				2'h3: pins_next.a_out = 1'b1;
				2'h2: pins_next.a_out = 1'b0;
				2'h1: pins_next.a_oe = 1'b0;
				2'h0: pins_next.a_out = ~cfg_reg.out_a_polarity;
			endcase
			unique case (cfg_reg.out_b_override_level)
				2'h3: pins_next.b_out = 1'b1;
				2'h2: pins_next.b_out = 1'b0;
				2'h1: pins_next.b_oe = 1'b0;
				2'h0: pins_next.b_out = ~cfg_reg.out_b_polarity;
			endcase
		end
		if (!cfg_reg.module_enable)
		begin
			pins_next.a_oe = 1'b0;
			pins_next.b_oe = 1'b0;
			pins_next.a_out = 1'b0;
			pins_next.b_out = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cfg_reg <= '0;
			st_reg <= '0;
			pins_reg <= '0;
			div_reg <= 3'h0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			st_reg <= st_next;
			pins_reg <= pins_next;
			div_reg <= div_next;
		end
	end

	assign drive_out_a = pins_reg.a_out;
	assign drive_out_a_oe = pins_reg.a_oe;
	assign drive_out_b = pins_reg.b_out;
	assign drive_out_b_oe = pins_reg.b_oe;
endmodule : cdg_complementary_generator

// File: cdg_gate_drv.sv
// Purpose: gate driver pair fed by the two outputs
// Assumes: each gate input has a pull-down
// Notes: counts cycles with both gates on
module cdg_gate_drv
(
	input wire logic ref_clk,
	input wire logic drive_out_a,
	input wire logic drive_out_a_oe,
	input wire logic drive_out_b,
	input wire logic drive_out_b_oe,
	output logic gate_a,
	output logic gate_b,
	output int shoots
);
	timeunit 1ns;
	timeprecision 1ps;
	// an undriven gate sinks to its pull-down
	assign gate_a = drive_out_a_oe ? drive_out_a : 1'b0;
	assign gate_b = drive_out_b_oe ? drive_out_b : 1'b0;
	initial shoots = 0;
	always @(posedge ref_clk)
		if (gate_a === 1'b1 && gate_b === 1'b1)
			shoots++;
endmodule : cdg_gate_drv

// File: cdg_pkg.sv
// Purpose: types for the complementary dead-band generator
// Assumes: nothing
// Notes: register images are packed structs
package cdg_pkg;
	typedef struct packed {
		logic module_enable;
		logic out_b_enable;
		logic out_a_enable;
		logic out_b_polarity;
		logic out_a_polarity;
		logic deadband_clock_select;
		logic [2:0] input_source_select;
		logic [1:0] out_a_override_level;
		logic [1:0] out_b_override_level;
		logic shutdown_status;
		logic auto_restart_enable;
		logic [3:0] shutdown_source_en;
		logic [5:0] rising_deadband_count;
		logic [5:0] falling_deadband_count;
	} cdg_cfg_s;
	typedef struct packed {
		logic a_out;
		logic a_oe;
		logic b_out;
		logic b_oe;
	} cdg_pins_s;
	typedef struct packed {
		logic [1:0] in_sync;
		logic [3:0] sd_sync0;
		logic [3:0] sd_sync1;
		logic in_prev;
		logic [6:0] cnt;
		logic rise_phase;
		logic counting;
		logic a_on;
		logic b_on;
		logic held;
		logic was_en;
		logic div_tick;
		logic [31:0] rdata;
		logic rvalid;
	} cdg_state_s;
endpackage : cdg_pkg

// File: cdg_props.sv
// Purpose: port checks for the dead-band generator
// Assumes: one clock, srst synchronous high
// Notes: control bytes are shadowed from bus writes
module cdg_props
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic fault_pin_n,
	input wire logic drive_out_a,
	input wire logic drive_out_a_oe,
	input wire logic drive_out_b,
	input wire logic drive_out_b_oe
);
	logic [23:0] c_reg;
	logic sd;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			c_reg <= 24'h0;
		else if (avs_write && !avs_waitrequest && avs_address[1:0] == 2'h0 && avs_address != 4'hC)
			c_reg[avs_address[3:2] * 8 +: 8] <= avs_writedata[7:0];
	end
	assign sd = c_reg[7] && c_reg[17] && !fault_pin_n;
	wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("answer not after one wait cycle");
	wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	rst_quiet_a: assert property ($fell(srst) |-> !drive_out_a_oe && !drive_out_b_oe)
		else $error("pins driven after reset");
	dis_off_a: assert property (!c_reg[7] [*4] |-> !drive_out_a_oe && !drive_out_b_oe && !drive_out_a)
		else $error("pins driven while disabled");
	ovr_high_a: assert property ((sd && c_reg[13:12] == 2'h3 && c_reg[5]) [*6] |-> drive_out_a && drive_out_a_oe)
		else $error("a not forced high in shutdown");
	ovr_low_a: assert property ((sd && c_reg[15:14] == 2'h2 && c_reg[6]) [*6] |-> !drive_out_b && drive_out_b_oe)
		else $error("b not forced low in shutdown");
	ovr_tri_a: assert property ((sd && c_reg[13:12] == 2'h1) [*6] |-> !drive_out_a_oe)
		else $error("a not released in shutdown");
	cover property (sd && c_reg[13:12] == 2'h3);
	cover property (avs_read && !avs_waitrequest);
	cover property ($rose(drive_out_a) && drive_out_a_oe);
endmodule : cdg_props
bind cdg_complementary_generator cdg_props chk (.ref_clk, .srst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .fault_pin_n, .drive_out_a,
	.drive_out_a_oe, .drive_out_b, .drive_out_b_oe);

// File: tb_top.sv
// Purpose: self-checking bench for the dead-band generator
// Assumes: one wait cycle per bus access
// Notes: read results are checked from a queue
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, lc2 = 1'b0, flt_n = 1'b1;
	logic [3:0] avs_address = 4'h0, be = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
	logic avs_waitrequest, drive_out_a, drive_out_a_oe, drive_out_b, drive_out_b_oe, ga, gb;
	logic [7:0] src = 8'h00;
	logic [2:0] sel;
	logic [5:0] rs[3] = '{6'h00, 6'h09, 6'h3F};
	logic [5:0] fs[3] = '{6'h05, 6'h01, 6'h00};
	logic [31:0] exp_q[$];
	int shoots, n, m, failures = 0, n_tests = 0, a_hi = 0;
	int seed = 32'h9EF3C094;
	cdg_complementary_generator uut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
		.comparator2_async_out(src[0]), .comparator1_async_out(src[1]), .pwm_unit1(src[2]),
		.pwm_unit2(src[3]), .pwm_unit3(src[4]), .pwm_unit4(src[5]), .oscillator_out(src[6]),
		.logic_cell1_out(src[7]), .logic_cell2_out(lc2), .fault_pin_n(flt_n), .drive_out_a,
		.drive_out_a_oe, .drive_out_b, .drive_out_b_oe);
	cdg_gate_drv gd (.ref_clk, .drive_out_a, .drive_out_a_oe, .drive_out_b, .drive_out_b_oe,
		.gate_a(ga), .gate_b(gb), .shoots);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// move the selected input, wait for the output that should turn on
	task automatic edge_to(input logic v);
		n = 0;
		@(posedge ref_clk);
		src[sel] <= v;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while ((v ? drive_out_a : drive_out_b) !== 1'b1 && n < 200);
		chk(32'(n < 200), 32'h1);
		chk(v ? drive_out_b : drive_out_a, 32'h0);
	endtask : edge_to
	task automatic wait_neg(input int k);
		repeat (k) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : wait_neg
	always @(negedge ref_clk)
	begin
		if (drive_out_a === 1'b1)
			a_hi++;
	end
	// read data taken at the edge where waitrequest is seen low
	always @(posedge ref_clk)
	begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
			chk(avs_readdata, exp_q.pop_front());
	end
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		failures++;
		report_and_stop;
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (rs[i]) rd(4'h4 * i[3:0], 32'h0);
		rd(4'hC, 32'h0);
		rd(4'h1, 32'h0);
		repeat (3)
		begin
			d = $random(seed);
			bus(1'b1, 4'h4, d);
			rd(4'h4, d & 32'hF7);
			bus(1'b1, 4'hC, d);
			rd(4'hC, d & 32'h3F3F);
		end
		$display("test registers done");
		sel = 3'h2;
		bus(1'b1, 4'h4, 32'h2);
		bus(1'b1, 4'h8, 32'h80);
		bus(1'b1, 4'h0, 32'hF8);
		wait_neg(4);
		chk(drive_out_a, 32'h0);
		chk(drive_out_b, 32'h0);
		bus(1'b1, 4'h8, 32'h0);
		foreach (rs[i])
		begin
			bus(1'b1, 4'hC, {18'h0, fs[i], 2'h0, rs[i]});
			edge_to(1'b1);
			m = n;
			edge_to(1'b0);
			chk(n - m, 32'(fs[i]) - 32'(rs[i]));
		end
		bus(1'b1, 4'hC, 32'h14);
		m = a_hi;
		@(posedge ref_clk);
		src[sel] <= 1'b1;
		repeat (5) @(posedge ref_clk);
		src[sel] <= 1'b0;
		wait_neg(40);
		chk(a_hi - m, 32'h0);
		bus(1'b1, 4'hC, 32'h0);
		for (int s = 0; s < 8; s++)
		begin
			sel = s[2:0];
			bus(1'b1, 4'h4, {29'h0, sel});
			edge_to(1'b1);
			edge_to(1'b0);
		end
		// slow dead-band clock: ten ticks of the divided rate
		bus(1'b1, 4'h0, 32'hF9);
		bus(1'b1, 4'hC, 32'h0A);
		edge_to(1'b1);
		chk(32'(n >= 60), 32'h1);
		edge_to(1'b0);
		bus(1'b1, 4'hC, 32'h0);
		bus(1'b1, 4'h0, 32'hF8);
		$display("test dead band done");
		sel = 3'h2;
		bus(1'b1, 4'h4, 32'hB2);
		bus(1'b1, 4'h8, 32'h02);
		flt_n <= 1'b0;
		wait_neg(6);
		chk(drive_out_a, 32'h1);
		chk(drive_out_b, 32'h0);
		bus(1'b1, 4'h8, 32'h02);
		rd(4'h8, 32'h82);
		flt_n <= 1'b1;
		wait_neg(6);
		bus(1'b1, 4'h8, 32'h02);
		rd(4'h8, 32'h02);
		wait_neg(4);
		chk(drive_out_a, 32'h1);
		edge_to(1'b1);
		bus(1'b1, 4'h4, 32'h52);
		flt_n <= 1'b0;
		wait_neg(6);
		chk(drive_out_a_oe, 32'h0);
		bus(1'b1, 4'h8, 32'h42);
		flt_n <= 1'b1;
		wait_neg(6);
		rd(4'h8, 32'h42);
		bus(1'b1, 4'h8, 32'h80);
		wait_neg(4);
		chk(drive_out_a_oe, 32'h0);
		rd(4'h8, 32'h80);
		bus(1'b1, 4'h8, 32'hC0);
		rd(4'h8, 32'h40);
		bus(1'b1, 4'h0, 32'h78);
		wait_neg(4);
		chk({drive_out_a_oe, drive_out_b_oe}, 32'h0);
		chk(shoots, 32'h0);
		$display("test shutdown done");
		report_and_stop;
	end
endmodule : tb_top
